// >>> gpio_cfg_pkg.sv
package gpio_cfg_pkg;

   // ****************************************************************
   // Subregister indices selected through the index register
   // ****************************************************************
   localparam logic [7:0] IDX_NONE        = 8'h00;
   localparam logic [7:0] IDX_DIRECTION   = 8'h01;
   localparam logic [7:0] IDX_ALT_ENABLE  = 8'h02;
   localparam logic [7:0] IDX_OPEN_DRAIN  = 8'h03;
   localparam logic [7:0] IDX_HIGH_DRIVE  = 8'h04;
   localparam logic [7:0] IDX_WAKE_ENABLE = 8'h05;
   localparam logic [7:0] IDX_PULLUP      = 8'h06;
   localparam logic [7:0] IDX_ALT_SEL_LO  = 8'h07;
   localparam logic [7:0] IDX_ALT_SEL_HI  = 8'h08;

   // ****************************************************************
   // Reset values
   // ****************************************************************
   localparam logic [7:0] RST_INDEX        = 8'h00;
   localparam logic [7:0] RST_DIRECTION    = 8'hff;
   localparam logic [7:0] RST_ALT_ENABLE   = 8'h00;
   localparam logic [7:0] RST_ALT_ENABLE_D = 8'h01;
   localparam logic [7:0] RST_OPEN_DRAIN   = 8'h00;
   localparam logic [7:0] RST_HIGH_DRIVE   = 8'h00;
   localparam logic [7:0] RST_WAKE_ENABLE  = 8'h00;
   localparam logic [7:0] RST_PULLUP       = 8'h00;
   localparam logic [7:0] RST_ALT_SEL      = 8'h00;

   // ****************************************************************
   // Carriers
   // ****************************************************************
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] wdata;
   } reg_access_t;

   // Per pin, what a peripheral offers for each of its four functions.
   typedef struct packed {
      logic [3:0] out;
      logic [3:0] oe;
   } alt_drive_t;

   typedef struct packed {
      logic out;
      logic oe;
      logic high_drive;
      logic pullup_en;
   } pad_ctrl_t;

endpackage

// >>> gpio_pin_ctrl.sv
`timescale 1ns/1ps
module gpio_pin_ctrl (
   input  wire logic                    port_out,
   input  wire logic                    direction,
   input  wire logic                    alt_enable,
   input  wire logic                    sel_lo,
   input  wire logic                    sel_hi,
   input  wire logic                    open_drain,
   input  wire logic                    high_drive,
   input  wire logic                    pullup_en,
   input  wire gpio_cfg_pkg::alt_drive_t alt,
   output wire gpio_cfg_pkg::pad_ctrl_t pad
);

   wire logic [1:0] alt_sel;
   wire logic       src_out;
   wire logic       src_oe;

   assign alt_sel = {sel_hi, sel_lo};
   assign src_out = alt_enable ? alt.out[alt_sel] : port_out;
   // Port mode drives only when the direction bit is zero.
   assign src_oe  = alt_enable ? alt.oe[alt_sel] : ~direction;

   // Open drain drops the high-side drive, so a one leaves the pin floating.
   assign pad.out        = src_out;
   assign pad.oe         = src_oe & ~(open_drain & src_out);
   assign pad.high_drive = high_drive;
   assign pad.pullup_en  = pullup_en;

endmodule

// >>> gpio_pin_function_drive_config.sv
// Functional notes
// - Index register selects subregister; 0, 9+ none.
// - Direction 0 drives output, 1 tristates, samples.
// - Index two reaches alternate-function enable.
// - Enable clear: plain port I/O by direction.
// - Enable set: peripheral controls pin, overriding direction.
// - Four functions chosen by two select bits.
// - Enable resets zero, port D resets one.
// - Index three reaches open-drain control.
// - Open-drain bit set disables high-side driver.
// - Open-drain bit clear keeps driver enabled.
// - Open-drain applies to alternate-function pins too.
// - Index four reaches high-drive enable.
// - High-drive bit selects pad drive strength.
// - High drive applies to alternate-function pins too.
`timescale 1ns/1ps
module gpio_pin_function_drive_config #(
   parameter int         PINS         = 8,
   parameter logic [7:0] ALT_EN_RESET = gpio_cfg_pkg::RST_ALT_ENABLE
) (
   input  wire logic                        clock,
   input  wire logic                        rst_n,
   input  wire logic                        index_wr,
   input  wire logic                        index_rd,
   input  wire gpio_cfg_pkg::reg_access_t   data_acc,
   input  wire logic [PINS-1:0]             out_data,
   input  wire logic [PINS-1:0]             pin_in,
   input  wire gpio_cfg_pkg::alt_drive_t [PINS-1:0] alt_drive,
   output logic [7:0]                       rdata,
   output logic [PINS-1:0]                  in_data,
   output logic [PINS-1:0]                  pin_out,
   output logic [PINS-1:0]                  pin_oe,
   output logic [PINS-1:0]                  pin_high_drive,
   output logic [PINS-1:0]                  pin_pullup
);

   // ****************************************************************
   // Configuration storage
   // ****************************************************************
   logic [7:0]      port_subregister_index_ff;
   logic [PINS-1:0] pin_direction_bit_ff;
   logic [PINS-1:0] alt_func_enable_bits_ff;
   logic [PINS-1:0] open_drain_bits_ff;
   logic [PINS-1:0] high_drive_bits_ff;
   logic [PINS-1:0] wake_enable_ff;
   logic [PINS-1:0] pullup_bits_ff;
   logic [PINS-1:0] alt_func_select_low_ff;
   logic [PINS-1:0] alt_func_select_high_ff;
   logic [7:0]      rdata_ff;
   logic [PINS-1:0] in_data_ff;
   logic [PINS-1:0] pin_out_ff;
   logic [PINS-1:0] pin_oe_ff;
   logic [PINS-1:0] pin_hd_ff;
   logic [PINS-1:0] pin_pu_ff;

   // ****************************************************************
   // Subregister decode
   // ****************************************************************
   wire logic [7:0] idx;
   wire logic       sel_dir;
   wire logic       sel_af;
   wire logic       sel_oc;
   wire logic       sel_hd;
   wire logic       sel_wk;
   wire logic       sel_pu;
   wire logic       sel_s1;
   wire logic       sel_s2;
   wire logic [PINS-1:0] wbits;
   logic [7:0]      nxt_rdata;

   assign idx     = port_subregister_index_ff;
   // Index zero and anything above eight match no select, so writes are dropped.
   assign sel_dir = idx == gpio_cfg_pkg::IDX_DIRECTION;
   assign sel_af  = idx == gpio_cfg_pkg::IDX_ALT_ENABLE;
   assign sel_oc  = idx == gpio_cfg_pkg::IDX_OPEN_DRAIN;
   assign sel_hd  = idx == gpio_cfg_pkg::IDX_HIGH_DRIVE;
   assign sel_wk  = idx == gpio_cfg_pkg::IDX_WAKE_ENABLE;
   assign sel_pu  = idx == gpio_cfg_pkg::IDX_PULLUP;
   assign sel_s1  = idx == gpio_cfg_pkg::IDX_ALT_SEL_LO;
   assign sel_s2  = idx == gpio_cfg_pkg::IDX_ALT_SEL_HI;
   assign wbits   = data_acc.wdata[PINS-1:0];

   always_comb begin
      nxt_rdata = 8'h00;
      if (index_rd) begin
         nxt_rdata = idx;
      end else if (data_acc.rd) begin
         case (idx)
            gpio_cfg_pkg::IDX_DIRECTION:   nxt_rdata[PINS-1:0] = pin_direction_bit_ff;
            gpio_cfg_pkg::IDX_ALT_ENABLE:  nxt_rdata[PINS-1:0] = alt_func_enable_bits_ff;
            gpio_cfg_pkg::IDX_OPEN_DRAIN:  nxt_rdata[PINS-1:0] = open_drain_bits_ff;
            gpio_cfg_pkg::IDX_HIGH_DRIVE:  nxt_rdata[PINS-1:0] = high_drive_bits_ff;
            gpio_cfg_pkg::IDX_WAKE_ENABLE: nxt_rdata[PINS-1:0] = wake_enable_ff;
            gpio_cfg_pkg::IDX_PULLUP:      nxt_rdata[PINS-1:0] = pullup_bits_ff;
            gpio_cfg_pkg::IDX_ALT_SEL_LO:  nxt_rdata[PINS-1:0] = alt_func_select_low_ff;
            gpio_cfg_pkg::IDX_ALT_SEL_HI:  nxt_rdata[PINS-1:0] = alt_func_select_high_ff;
            default:                       nxt_rdata = 8'h00;
         endcase
      end
   end

   // ****************************************************************
   // Register writes
   // ****************************************************************
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         port_subregister_index_ff <= gpio_cfg_pkg::RST_INDEX;
      end else if (index_wr) begin
         port_subregister_index_ff <= data_acc.wdata;
      end
   end

   // One short block per subregister, so a write can only touch the one selected.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pin_direction_bit_ff <= PINS'(gpio_cfg_pkg::RST_DIRECTION);
      end else if (data_acc.wr && sel_dir) begin
         pin_direction_bit_ff <= wbits;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         alt_func_enable_bits_ff <= PINS'(ALT_EN_RESET);
      end else if (data_acc.wr && sel_af) begin
         alt_func_enable_bits_ff <= wbits;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         open_drain_bits_ff <= PINS'(gpio_cfg_pkg::RST_OPEN_DRAIN);
      end else if (data_acc.wr && sel_oc) begin
         open_drain_bits_ff <= wbits;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         high_drive_bits_ff <= PINS'(gpio_cfg_pkg::RST_HIGH_DRIVE);
      end else if (data_acc.wr && sel_hd) begin
         high_drive_bits_ff <= wbits;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         wake_enable_ff <= PINS'(gpio_cfg_pkg::RST_WAKE_ENABLE);
      end else if (data_acc.wr && sel_wk) begin
         wake_enable_ff <= wbits;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pullup_bits_ff <= PINS'(gpio_cfg_pkg::RST_PULLUP);
      end else if (data_acc.wr && sel_pu) begin
         pullup_bits_ff <= wbits;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         alt_func_select_low_ff <= PINS'(gpio_cfg_pkg::RST_ALT_SEL);
      end else if (data_acc.wr && sel_s1) begin
         alt_func_select_low_ff <= wbits;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         alt_func_select_high_ff <= PINS'(gpio_cfg_pkg::RST_ALT_SEL);
      end else if (data_acc.wr && sel_s2) begin
         alt_func_select_high_ff <= wbits;
      end
   end

   // ****************************************************************
   // Per-pin pad control
   // ****************************************************************
   wire gpio_cfg_pkg::pad_ctrl_t [PINS-1:0] pad;

   for (genvar p = 0; p < PINS; p++) begin : g_pin
      gpio_pin_ctrl u_pin (
         .port_out   (out_data[p]),
         .direction  (pin_direction_bit_ff[p]),
         .alt_enable (alt_func_enable_bits_ff[p]),
         .sel_lo     (alt_func_select_low_ff[p]),
         .sel_hi     (alt_func_select_high_ff[p]),
         .open_drain (open_drain_bits_ff[p]),
         .high_drive (high_drive_bits_ff[p]),
         .pullup_en  (pullup_bits_ff[p]),
         .alt        (alt_drive[p]),
         .pad        (pad[p])
      );
   end

   // ****************************************************************
   // Output flops
   // ****************************************************************
   // Pad controls are registered, so a config write reaches the pin one cycle later.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rdata_ff   <= 8'h00;
         in_data_ff <= '0;
         pin_out_ff <= '0;
         pin_oe_ff  <= '0;
         pin_hd_ff  <= '0;
         pin_pu_ff  <= '0;
      end else begin
         rdata_ff <= nxt_rdata;
         // Inputs sample every cycle; an output pin reads back its own level.
         in_data_ff <= pin_in;
         for (int i = 0; i < PINS; i++) begin
            pin_out_ff[i] <= pad[i].out;
            pin_oe_ff[i]  <= pad[i].oe;
            pin_hd_ff[i]  <= pad[i].high_drive;
            pin_pu_ff[i]  <= pad[i].pullup_en;
         end
      end
   end

   assign rdata          = rdata_ff;
   assign in_data        = in_data_ff;
   assign pin_out        = pin_out_ff;
   assign pin_oe         = pin_oe_ff;
   assign pin_high_drive = pin_hd_ff;
   assign pin_pullup     = pin_pu_ff;

endmodule

// >>> gpio_pad_model.sv
`timescale 1ns/1ps
module gpio_pad_model #(
   parameter int PINS = 8
) (
   input  wire logic [PINS-1:0] pin_out,
   input  wire logic [PINS-1:0] pin_oe,
   input  wire logic [PINS-1:0] pin_pullup,
   input  wire logic [PINS-1:0] ext_val,
   input  wire logic [PINS-1:0] ext_oe,
   input  wire logic            clock,
   output logic      [PINS-1:0] pin_in
);
   // Starts low so that a floating pin shows a defined level from the first cycle.
   logic [PINS-1:0] last_ff = '0;
   // A floating pin without pull-up shows the inverse of its last level, so a lost drive shows.
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_oe & ext_val)
                 | (~pin_oe & ~ext_oe & (pin_pullup | ~last_ff));
   always @(posedge clock) begin
      last_ff <= pin_in;
   end
endmodule

// >>> gpio_cfg_chk.sv
`timescale 1ns/1ps
module gpio_cfg_chk #(
   parameter int PINS = 8
) (
   input wire logic                      clock,
   input wire logic                      rst_n,
   input wire logic                      index_wr,
   input wire logic                      index_rd,
   input wire gpio_cfg_pkg::reg_access_t data_acc,
   input wire logic [7:0]                rdata,
   input wire logic [PINS-1:0]           pin_out,
   input wire logic [PINS-1:0]           pin_oe,
   input wire logic [PINS-1:0]           pin_high_drive
);
   // *****************************************
   // Shadow of the index register
   // *****************************************
   logic [7:0] idx_ff;
   wire        idx_none = (idx_ff == 8'h00) || (idx_ff > 8'h08);
   wire        idx_cfg  = (idx_ff >= 8'h02) && (idx_ff <= 8'h04);
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n)
         idx_ff <= 8'h00;
      else if (index_wr)
         idx_ff <= data_acc.wdata;
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   sequence s_cfg_write;
      data_acc.wr && !index_wr && idx_cfg;
   endsequence
   sequence s_plain_read;
      data_acc.rd && !index_rd && !index_wr && !data_acc.wr;
   endsequence
   property p_idle_read;
      !(data_acc.rd || index_rd) |=> rdata == 8'h00;
   endproperty
   a_idle_read: assert property (p_idle_read) else $error("rdata not zero when idle");
   property p_index_read;
      index_wr ##1 (index_rd && !index_wr) |=> rdata == $past(data_acc.wdata, 2);
   endproperty
   a_index_read: assert property (p_index_read) else $error("index read wrong");
   property p_none_read;
      data_acc.rd && !index_rd && idx_none |=> rdata == 8'h00;
   endproperty
   a_none_read: assert property (p_none_read) else $error("unmapped read not zero");
   property p_write_read;
      s_cfg_write ##1 s_plain_read |=> rdata == $past(data_acc.wdata, 2);
   endproperty
   a_write_read: assert property (p_write_read) else $error("readback wrong");
   property p_hd_out;
      data_acc.wr && !index_wr && idx_ff == 8'h04 |=> ##1 pin_high_drive == $past(data_acc.wdata, 2);
   endproperty
   a_hd_out: assert property (p_hd_out) else $error("drive strength wrong");
   property p_od;
      data_acc.wr && !index_wr && idx_ff == 8'h03 |=> ##1 (pin_oe & pin_out & $past(data_acc.wdata, 2)) == '0;
   endproperty
   a_od: assert property (p_od) else $error("open drain pin drives high");
   property p_hd_stable;
      !data_acc.wr |=> ##1 $stable(pin_high_drive);
   endproperty
   a_hd_stable: assert property (p_hd_stable) else $error("drive changed unasked");
   property p_reset;
      disable iff (1'b0) !rst_n |-> pin_oe == '0 && pin_high_drive == '0 && rdata == 8'h00;
   endproperty
   a_reset: assert property (p_reset) else $error("outputs not clear in reset");
endmodule
bind gpio_pin_function_drive_config gpio_cfg_chk #(.PINS(PINS)) chk (.clock(clock), .rst_n(rst_n),
   .index_wr(index_wr), .index_rd(index_rd), .data_acc(data_acc), .rdata(rdata),
   .pin_out(pin_out), .pin_oe(pin_oe), .pin_high_drive(pin_high_drive));

// >>> tb_top.sv
`timescale 1ns/1ps
module tb_top;
   logic                           clock = 1'b0;
   logic                           rst_n;
   logic                           index_wr = 1'b0;
   logic                           index_rd = 1'b0;
   gpio_cfg_pkg::reg_access_t      data_acc = '0;
   logic [7:0]                     out_data = 8'h00;
   gpio_cfg_pkg::alt_drive_t [7:0] alt_drive = {8{8'h6b}};
   logic [7:0]                     ext_val = 8'h00;
   logic [7:0]                     ext_oe = 8'h00;
   logic [7:0]                     pin_in, rdata, in_data, pin_out, pin_oe, pin_high_drive, pin_pullup;
   int                             fails = 0;
   int                             check_count = 0;
   int                             cycles = 0;
   always #10 clock = ~clock;
   // The instance stands as the port whose alternate function is enabled on pin 0 at reset.
   gpio_pin_function_drive_config #(.PINS(8), .ALT_EN_RESET(gpio_cfg_pkg::RST_ALT_ENABLE_D)) DUT (
      .clock(clock), .rst_n(rst_n), .index_wr(index_wr), .index_rd(index_rd), .data_acc(data_acc),
      .out_data(out_data), .pin_in(pin_in), .alt_drive(alt_drive), .rdata(rdata), .in_data(in_data),
      .pin_out(pin_out), .pin_oe(pin_oe), .pin_high_drive(pin_high_drive), .pin_pullup(pin_pullup));
   gpio_pad_model #(.PINS(8)) pads (.pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
      .ext_val(ext_val), .ext_oe(ext_oe), .clock(clock), .pin_in(pin_in));
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      check_count++;
      if (got !== exp) begin
         $display("unexpected %s expected %h seen %h", name, exp, got);
         fails++;
      end
   endtask
   task automatic put_index(input logic [7:0] v);
      index_wr = 1'b1;
      data_acc.wdata = v;
      cyc(1);
      index_wr = 1'b0;
   endtask
   task automatic put_data(input logic [7:0] i, input logic [7:0] v);
      put_index(i);
      data_acc.wr = 1'b1;
      data_acc.wdata = v;
      cyc(1);
      data_acc.wr = 1'b0;
   endtask
   task automatic rd_now(input logic [7:0] exp, input string name);
      data_acc.rd = 1'b1;
      cyc(1);
      data_acc.rd = 1'b0;
      chk(name, exp, rdata);
   endtask
   task automatic rd_chk(input logic [7:0] i, input logic [7:0] exp, input string name);
      put_index(i);
      rd_now(exp, name);
   endtask
   task automatic t_regs();
      logic [7:0] bad [3] = '{8'h00, 8'h09, 8'hff};
      rd_chk(8'h02, 8'h01, "alt enable reset");
      rd_chk(8'h03, 8'h00, "open drain reset");
      rd_chk(8'h04, 8'h00, "high drive reset");
      for (int i = 2; i <= 4; i++) begin
         put_data(8'(i), 8'ha5 ^ 8'(i));
         rd_now(8'ha5 ^ 8'(i), "subregister readback");
      end
      foreach (bad[k]) begin
         put_data(bad[k], 8'h3c);
         rd_chk(bad[k], 8'h00, "unmapped read");
      end
      rd_chk(8'h03, 8'ha6, "open drain kept");
      put_index(8'h07);
      index_rd = 1'b1;
      cyc(1);
      index_rd = 1'b0;
      chk("index read", 8'h07, rdata);
      $display("test regs done");
   endtask
   task automatic t_port();
      put_data(8'h02, 8'h00);
      put_data(8'h03, 8'h00);
      put_data(8'h05, 8'h3c);
      rd_now(8'h3c, "wake enable readback");
      put_data(8'h06, 8'h0f);
      put_data(8'h01, 8'hf0);
      out_data = 8'h5a;
      ext_oe = 8'hf0;
      ext_val = 8'ha0;
      cyc(3);
      chk("port oe", 8'h0f, pin_oe);
      chk("port out", 8'h0a, pin_out & pin_oe);
      chk("port in", 8'haa, in_data);
      chk("pullup", 8'h0f, pin_pullup);
      $display("test port done");
   endtask
   task automatic t_alt();
      logic [3:0] oe_pat = 4'hb;
      logic [3:0] out_pat = 4'h6;
      put_data(8'h01, 8'hff);
      put_data(8'h02, 8'hff);
      for (int s = 0; s < 4; s++) begin
         put_data(8'h03, 8'h00);
         put_data(8'h04, {4{2'(s)}});
         put_data(8'h07, {8{s[0]}});
         put_data(8'h08, {8{s[1]}});
         cyc(2);
         chk("alt oe", {8{oe_pat[s]}}, pin_oe);
         chk("alt out", {8{out_pat[s]}}, pin_out);
         chk("high drive", {4{2'(s)}}, pin_high_drive);
         put_data(8'h03, 8'hff);
         cyc(2);
         chk("alt open drain", {8{oe_pat[s] & ~out_pat[s]}}, pin_oe);
      end
      $display("test alt done");
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   always @(posedge clock) begin
      cycles++;
      if (cycles == 3000) begin
         fails++;
         final_report();
      end
   end
   initial begin
      rst_n = 1'b0;
      cyc(10);
      rst_n = 1'b1;
      t_regs();
      t_port();
      t_alt();
      final_report();
   end
endmodule
